// File: inc/frsb_defs.vh
// frsb_defs.vh: register map, field positions, command codes and timing counts
// assumes: included by every frsb design file, clock at FRSB_CLK_MHZ
`ifndef FRSB_DEFS_VH
`define FRSB_DEFS_VH

// ==========================================================
// clock and timing
`define FRSB_CLK_MHZ 200
`define FRSB_OP_TIME_NS 1000
`define FRSB_OP_CYCLES ((`FRSB_OP_TIME_NS * `FRSB_CLK_MHZ + 999) / 1000)
`define FRSB_BAUD_NS 1000
`define FRSB_BAUD_DIV ((`FRSB_BAUD_NS * `FRSB_CLK_MHZ) / 1000)

// ==========================================================
// register byte offsets
`define FRSB_REG_MODE 8'h00
`define FRSB_REG_CTRL_A 8'h04
`define FRSB_REG_CTRL_B 8'h08
`define FRSB_REG_STATUS 8'h0C
`define FRSB_REG_ID 8'h10
`define FRSB_REG_LOCKS 8'h14

// ==========================================================
// field positions
`define FRSB_MODE_ENABLE_BIT 0
`define FRSB_CTRLA_SELECT_BIT 0
`define FRSB_CTRLA_CMD_LSB 4
`define FRSB_CTRLA_BLOCK_LSB 8
`define FRSB_CTRLA_DATA_LSB 16
`define FRSB_CTRLB_LPD_BIT 0
`define FRSB_STAT_READY_BIT 0
`define FRSB_STAT_ERROR_BIT 1
`define FRSB_STAT_ABORT_BIT 2

// ==========================================================
// commands and reset values
`define FRSB_CMD_NONE 3'h0
`define FRSB_CMD_PROGRAM 3'h1
`define FRSB_CMD_ERASE 3'h2
`define FRSB_CMD_LOCK 3'h3
`define FRSB_CMD_PROTECT 3'h4
`define FRSB_ID_RESET 8'h5A
`define FRSB_ERASED 8'hFF
`define FRSB_SER_WRITE_BIT 7

`endif

// File: src/frsb_serial.v
// frsb_serial.v: byte transmitter/receiver for the serial boot link
// assumes: sclk and rxd already pass two flip-flops in the parent
`include "frsb_defs.vh"

module frsb_serial #(
  parameter BAUD_DIV = `FRSB_BAUD_DIV
) (
  input wire i_clock,
  input wire i_resetn,
  input wire i_mode2,
  input wire i_sclk_s,
  input wire i_rxd_s,
  input wire i_tx_start,
  input wire [7:0] i_tx_byte,
  output reg o_rx_valid,
  output reg [7:0] o_rx_byte,
  output reg o_txd,
  output reg o_tx_busy
);

  reg sclk_d_q;
  reg [3:0] rx_cnt_q;
  reg [7:0] rx_sh_q;
  reg rx_act_q;
  reg [15:0] rx_div_q;
  reg [3:0] tx_cnt_q;
  reg [9:0] tx_sh_q;
  reg [15:0] tx_div_q;
  wire sclk_rise = i_sclk_s & ~sclk_d_q;
  wire sclk_fall = ~i_sclk_s & sclk_d_q;
  wire rx_tick = (rx_div_q == 16'h0000);
  wire tx_tick = (tx_div_q == 16'h0000);

  // ==========================================================
  // receive: clocked bits in mode 1, start/stop frames in mode 2
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_d_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_act_q <= 1'b0;
      rx_div_q <= 16'h0000;
      o_rx_valid <= 1'b0;
      o_rx_byte <= 8'h00;
    end else begin
      sclk_d_q <= i_sclk_s;
      o_rx_valid <= 1'b0;
      if (!i_mode2) begin
        if (sclk_rise) begin
          rx_sh_q <= {i_rxd_s, rx_sh_q[7:1]};
          if (rx_cnt_q == 4'h7) begin
            rx_cnt_q <= 4'h0;
            o_rx_valid <= 1'b1;
            o_rx_byte <= {i_rxd_s, rx_sh_q[7:1]};
          end else begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
          end
        end
      end else if (!rx_act_q) begin
        if (!i_rxd_s) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= 4'h0;
          rx_div_q <= BAUD_DIV[15:0] >> 1;
        end
      end else if (rx_tick) begin
        rx_div_q <= BAUD_DIV[15:0] - 16'h0001;
        rx_cnt_q <= rx_cnt_q + 4'h1;
        if (rx_cnt_q == 4'h0 && i_rxd_s) begin
          rx_act_q <= 1'b0;
        end else if (rx_cnt_q == 4'h9) begin
          rx_act_q <= 1'b0;
          o_rx_valid <= i_rxd_s;
          o_rx_byte <= rx_sh_q;
        end else if (rx_cnt_q != 4'h0) begin
          rx_sh_q <= {i_rxd_s, rx_sh_q[7:1]};
        end
      end else begin
        rx_div_q <= rx_div_q - 16'h0001;
      end
    end
  end

  // ==========================================================
  // transmit: shift on sclk fall in mode 1, baud ticks in mode 2
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_cnt_q <= 4'h0;
      tx_sh_q <= 10'h3FF;
      tx_div_q <= 16'h0000;
      o_txd <= 1'b1;
      o_tx_busy <= 1'b0;
    end else if (i_tx_start && !o_tx_busy) begin
      o_tx_busy <= 1'b1;
      tx_cnt_q <= 4'h0;
      tx_div_q <= BAUD_DIV[15:0] - 16'h0001;
      tx_sh_q <= i_mode2 ? {1'b1, i_tx_byte, 1'b0} : {2'b11, i_tx_byte};
      o_txd <= i_mode2 ? 1'b0 : i_tx_byte[0];
    end else if (o_tx_busy) begin
      if (!i_mode2) begin
        if (sclk_fall) begin
          tx_sh_q <= {1'b1, tx_sh_q[9:1]};
          o_txd <= tx_sh_q[1];
          tx_cnt_q <= tx_cnt_q + 4'h1;
          if (tx_cnt_q == 4'h7) begin
            o_tx_busy <= 1'b0;
          end
        end
      end else if (tx_tick) begin
        tx_div_q <= BAUD_DIV[15:0] - 16'h0001;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        o_txd <= tx_sh_q[1];
        tx_cnt_q <= tx_cnt_q + 4'h1;
        if (tx_cnt_q == 4'h9) begin
          o_tx_busy <= 1'b0;
        end
      end else begin
        tx_div_q <= tx_div_q - 16'h0001;
      end
    end
  end

endmodule // frsb_serial

// File: src/frsb_top.v
// frsb_top.v: flash rewrite sequencer with abort handling and serial boot port
// assumes: Avalon-MM master on i_clock, abort events from same-clock logic
//
// The address map and register access over Avalon-MM were decided locally.
`include "frsb_defs.vh"

module frsb_top #(
  parameter BLOCKS = 8,
  parameter OP_CYCLES = `FRSB_OP_CYCLES,
  parameter BAUD_DIV = `FRSB_BAUD_DIV,
  parameter [7:0] ID_RESET = `FRSB_ID_RESET // arbitrary value
) (
  input wire i_clock,
  input wire i_resetn,
  input wire [7:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  output reg [31:0] o_readdata,
  output reg o_waitrequest,
  input wire i_nmi,
  input wire i_wdt_irq,
  input wire i_osc_stop_irq,
  input wire i_low_volt_irq,
  input wire i_serial_mode2,
  input wire i_sclk,
  input wire i_rxd,
  output reg o_txd,
  output reg o_busy,
  output reg o_read_array,
  output reg o_trap_fetch_inhibit
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;
  localparam SS_ID = 2'h0;
  localparam SS_CMD = 2'h1;
  localparam SS_DATA = 2'h2;

  reg [1:0] mode_sync_q, sclk_sync_q, rxd_sync_q;
  reg enable_q, select_q, lpd_q, state_q, ready_q, error_q, abort_q;
  reg [2:0] cmd_q, block_q;
  reg [7:0] data_q, id_q, wr_addr_q, tx_byte_q;
  reg [BLOCKS-1:0] lock_q, prot_q, undef_q;
  reg [7:0] mem_q [0:BLOCKS-1];
  reg [15:0] cnt_q;
  reg [1:0] ser_state_q;
  reg tx_start_q;
  reg [31:0] rd_d;
  wire rx_valid, txd_w, tx_busy;
  wire [7:0] rx_byte;
  wire acc = o_waitrequest & (i_read | i_write);
  wire wr_go = i_write & ~o_waitrequest;
  wire abort_evt = i_nmi | i_wdt_irq | i_osc_stop_irq | i_low_volt_irq;
  wire guarded = lock_q[block_q] | prot_q[block_q] | undef_q[block_q];
  wire mode2 = mode_sync_q[1];
  integer i;

  function [2:0] frsb_blk;
    input [7:0] a;
    begin
      frsb_blk = a[2:0];
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_sync_q <= 2'b00;
      sclk_sync_q <= 2'b00;
      rxd_sync_q <= 2'b11;
    end else begin
      mode_sync_q <= {mode_sync_q[0], i_serial_mode2};
      sclk_sync_q <= {sclk_sync_q[0], i_sclk};
      rxd_sync_q <= {rxd_sync_q[0], i_rxd};
    end
  end

  // ==========================================================
  // bus read mux
  always @* begin
    rd_d = 32'h00000000;
    case (i_address)
      `FRSB_REG_MODE: rd_d[`FRSB_MODE_ENABLE_BIT] = enable_q;
      `FRSB_REG_CTRL_A: begin
        rd_d[`FRSB_CTRLA_SELECT_BIT] = select_q;
        rd_d[`FRSB_CTRLA_CMD_LSB +: 3] = cmd_q;
        rd_d[`FRSB_CTRLA_BLOCK_LSB +: 3] = block_q;
        rd_d[`FRSB_CTRLA_DATA_LSB +: 8] = data_q;
      end
      `FRSB_REG_CTRL_B: rd_d[`FRSB_CTRLB_LPD_BIT] = lpd_q;
      `FRSB_REG_STATUS: begin
        rd_d[`FRSB_STAT_READY_BIT] = ready_q;
        rd_d[`FRSB_STAT_ERROR_BIT] = error_q;
        rd_d[`FRSB_STAT_ABORT_BIT] = abort_q;
      end
      `FRSB_REG_ID: rd_d[7:0] = id_q;
      `FRSB_REG_LOCKS: begin
        rd_d[BLOCKS-1:0] = lock_q;
        rd_d[8 +: BLOCKS] = prot_q;
        rd_d[16 +: BLOCKS] = undef_q;
      end
      default: rd_d = 32'h00000000;
    endcase
  end

  // ==========================================================
  // bus handshake: one wait cycle, then the request completes
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h00000000;
    end else begin
      o_waitrequest <= ~acc;
      if (acc && i_read) begin
        o_readdata <= rd_d;
      end
    end
  end

  // ==========================================================
  // rewrite sequencer and software registers
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      enable_q <= 1'b0;
      select_q <= 1'b0;
      lpd_q <= 1'b0;
      state_q <= ST_IDLE;
      ready_q <= 1'b1;
      error_q <= 1'b0;
      abort_q <= 1'b0;
      cmd_q <= `FRSB_CMD_NONE;
      block_q <= 3'h0;
      data_q <= 8'h00;
      id_q <= ID_RESET;
      cnt_q <= 16'h0000;
      lock_q <= {BLOCKS{1'b0}};
      prot_q <= {BLOCKS{1'b0}};
      undef_q <= {BLOCKS{1'b0}};
      o_read_array <= 1'b1;
      o_trap_fetch_inhibit <= 1'b0;
      for (i = 0; i < BLOCKS; i = i + 1) begin
        mem_q[i] <= `FRSB_ERASED;
      end
      wr_addr_q <= 8'h00;
      ser_state_q <= SS_ID;
      tx_start_q <= 1'b0;
      tx_byte_q <= 8'h00;
    end else begin
      tx_start_q <= 1'b0;
      o_read_array <= (state_q == ST_IDLE);
      o_trap_fetch_inhibit <= enable_q & ~select_q;
      if (abort_evt && enable_q) begin
        // control A and status back to reset, array readable again
        state_q <= ST_IDLE;
        select_q <= 1'b0;
        cmd_q <= `FRSB_CMD_NONE;
        block_q <= 3'h0;
        data_q <= 8'h00;
        ready_q <= 1'b1;
        error_q <= 1'b0;
        abort_q <= 1'b0;
        o_read_array <= 1'b1;
        if (state_q == ST_RUN && cmd_q == `FRSB_CMD_ERASE) begin
          undef_q[block_q] <= 1'b1;
        end
      end else if (state_q == ST_RUN) begin
        if (cnt_q == 16'h0000) begin
          state_q <= ST_IDLE;
          ready_q <= 1'b1;
          if (guarded && !lpd_q) begin
            error_q <= 1'b1;
          end else begin
            case (cmd_q)
              `FRSB_CMD_PROGRAM: mem_q[block_q] <= data_q;
              `FRSB_CMD_ERASE: begin
                mem_q[block_q] <= `FRSB_ERASED;
                undef_q[block_q] <= 1'b0;
                lock_q[block_q] <= 1'b0;
                prot_q[block_q] <= 1'b0;
              end
              `FRSB_CMD_LOCK: lock_q[block_q] <= 1'b1;
              `FRSB_CMD_PROTECT: prot_q[block_q] <= 1'b1;
              default: error_q <= 1'b1;
            endcase
          end
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end else if (wr_go) begin
        case (i_address)
          `FRSB_REG_MODE: enable_q <= i_writedata[`FRSB_MODE_ENABLE_BIT];
          `FRSB_REG_CTRL_A: begin
            select_q <= i_writedata[`FRSB_CTRLA_SELECT_BIT];
            cmd_q <= i_writedata[`FRSB_CTRLA_CMD_LSB +: 3];
            block_q <= i_writedata[`FRSB_CTRLA_BLOCK_LSB +: 3];
            data_q <= i_writedata[`FRSB_CTRLA_DATA_LSB +: 8];
            if (enable_q && i_writedata[`FRSB_CTRLA_CMD_LSB +: 3] != `FRSB_CMD_NONE) begin
              state_q <= ST_RUN;
              ready_q <= 1'b0;
              error_q <= 1'b0;
              abort_q <= 1'b0;
              cnt_q <= OP_CYCLES[15:0] - 16'h0001;
            end
          end
          `FRSB_REG_CTRL_B: lpd_q <= i_writedata[`FRSB_CTRLB_LPD_BIT];
          `FRSB_REG_STATUS: begin
            error_q <= error_q & ~i_writedata[`FRSB_STAT_ERROR_BIT];
          end
          `FRSB_REG_ID: id_q <= i_writedata[7:0];
          default: ;
        endcase
      end
      if (abort_evt && enable_q && state_q == ST_RUN) begin
        abort_q <= 1'b0;
      end

      // serial boot commands: id byte, then {write, addr} and data
      if (rx_valid) begin
        case (ser_state_q)
          SS_ID: begin
            if (rx_byte == id_q) begin
              ser_state_q <= SS_CMD;
            end
          end
          SS_CMD: begin
            if (rx_byte[`FRSB_SER_WRITE_BIT]) begin
              wr_addr_q <= rx_byte;
              ser_state_q <= SS_DATA;
            end else begin
              tx_byte_q <= mem_q[frsb_blk(rx_byte)];
              tx_start_q <= 1'b1;
            end
          end
          SS_DATA: begin
            if (state_q == ST_IDLE) begin
              mem_q[frsb_blk(wr_addr_q)] <= rx_byte;
            end
            ser_state_q <= SS_CMD;
          end
          default: ser_state_q <= SS_ID;
        endcase
      end
    end
  end

  // ==========================================================
  // pin outputs
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_txd <= 1'b1;
      o_busy <= 1'b0;
    end else begin
      o_txd <= txd_w;
      // handshake busy in mode 1, operation monitor in mode 2
      o_busy <= mode2 ? (state_q == ST_RUN)
                      : (tx_busy | tx_start_q | (ser_state_q == SS_DATA));
    end
  end

  frsb_serial #(
    .BAUD_DIV(BAUD_DIV)
  ) u_serial (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_mode2(mode2),
    .i_sclk_s(sclk_sync_q[1]),
    .i_rxd_s(rxd_sync_q[1]),
    .i_tx_start(tx_start_q),
    .i_tx_byte(tx_byte_q),
    .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte),
    .o_txd(txd_w),
    .o_tx_busy(tx_busy)
  );

endmodule // frsb_top

// File: test/frsb_top_assertions.sv
// frsb_top_assertions.sv: port checker for frsb_top
// assumes: bound to frsb_top, single clock domain
module frsb_chk #(
  parameter OP_CYCLES = 200
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic i_nmi,
  input wire logic i_wdt_irq,
  input wire logic i_osc_stop_irq,
  input wire logic i_low_volt_irq,
  input wire logic i_serial_mode2,
  input wire logic o_waitrequest,
  input wire logic o_txd,
  input wire logic o_busy,
  input wire logic o_read_array
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  wire abort_ev = i_nmi | i_wdt_irq | i_osc_stop_irq | i_low_volt_irq;
  logic [15:0] run_q;
  // ==========================================================
  // run length counter
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) run_q <= 16'h0000;
    else run_q <= o_read_array ? 16'h0000 : run_q + 16'h0001;
  end
  // ==========================================================
  // properties
  wait_answer_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("waitrequest did not drop");
  wait_single_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low too long");
  wait_idle_a: assert property (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
    else $error("waitrequest dropped with no request");
  abort_cut_a: assert property (abort_ev && !o_read_array |-> ##[1:2] o_read_array)
    else $error("abort did not return to read array");
  op_bound_a: assert property (run_q <= OP_CYCLES + 2)
    else $error("operation ran too long");
  monitor_busy_a: assert property (i_serial_mode2 && $past(i_serial_mode2, 3)
    && $fell(o_read_array) |-> ##[0:2] o_busy)
    else $error("monitor did not show running operation");
  monitor_idle_a: assert property ((i_serial_mode2 && o_read_array)[*3] |-> !o_busy)
    else $error("monitor high while idle");
  txd_idle_a: assert property ((!i_serial_mode2 && !o_busy)[*8] |-> o_txd)
    else $error("transmit line not idle");
endmodule // frsb_chk

bind frsb_top frsb_chk #(.OP_CYCLES(OP_CYCLES)) u_frsb_chk (
  .i_clock(i_clock),
  .i_resetn(i_resetn),
  .i_read(i_read),
  .i_write(i_write),
  .i_nmi(i_nmi),
  .i_wdt_irq(i_wdt_irq),
  .i_osc_stop_irq(i_osc_stop_irq),
  .i_low_volt_irq(i_low_volt_irq),
  .i_serial_mode2(i_serial_mode2),
  .o_waitrequest(o_waitrequest),
  .o_txd(o_txd),
  .o_busy(o_busy),
  .o_read_array(o_read_array)
);

// File: test/frsb_prog.sv
// frsb_prog.sv: clocked and uart serial programmer model
// assumes: tasks called by the bench, clock low outside frames
module frsb_prog (
  input wire logic i_mode2,
  input wire logic i_txd,
  output logic o_sclk,
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 100ps;
  // uart bit time: bench baud divider 8 at 5 ns
  localparam int BIT_NS = 40;
  // ==========================================================
  // idle levels
  initial begin
    o_sclk = 1'b0;
    o_rxd = 1'b1;
  end
  // ==========================================================
  // byte transfers, lsb first, 160 ns clock
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      o_rxd = b[i];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    o_rxd = 1'b1;
  endtask
  task automatic recv_byte(output logic [7:0] b);
    // bit 0 stands now; the command's last fall already moves to bit 1
    b[0] = i_txd;
    for (int i = 1; i < 8; i++) begin
      #80 o_sclk = 1'b1;
      b[i] = i_txd;
      #80 o_sclk = 1'b0;
    end
  endtask
  // ==========================================================
  // uart frames for mode 2, sclk stays low
  task automatic send_uart(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd = f[i];
      #BIT_NS;
    end
  endtask
  task automatic xfer_uart(input logic [7:0] t, output logic [7:0] b);
    fork
      send_uart(t);
      begin
        @(negedge i_txd);
        #(BIT_NS * 3 / 2);
        for (int i = 0; i < 8; i++) begin
          b[i] = i_txd;
          #BIT_NS;
        end
      end
    join
  endtask
endmodule // frsb_prog

// File: test/frsb_top_tb.sv
// frsb_top_tb.sv: self-checking bench for frsb_top
// assumes: frsb_prog as serial partner, checker bound separately
`include "frsb_defs.vh"
module frsb_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OPC = 40;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h00000000;
  logic i_nmi = 1'b0;
  logic i_wdt_irq = 1'b0;
  logic i_osc_stop_irq = 1'b0;
  logic i_low_volt_irq = 1'b0;
  logic i_serial_mode2 = 1'b0;
  logic sclk;
  logic rxd;
  wire [31:0] o_readdata;
  wire o_waitrequest, o_txd, o_busy, o_read_array, o_trap_fetch_inhibit;
  int bad_count = 0;
  int comparisons = 0;
  always #2.5 i_clock = ~i_clock;
  // id value is arbitrary
  frsb_top #(.OP_CYCLES(OPC), .BAUD_DIV(8), .ID_RESET(8'h3C)) u_frsb_top (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_nmi(i_nmi), .i_wdt_irq(i_wdt_irq),
    .i_osc_stop_irq(i_osc_stop_irq), .i_low_volt_irq(i_low_volt_irq),
    .i_serial_mode2(i_serial_mode2), .i_sclk(sclk), .i_rxd(rxd), .o_txd(o_txd),
    .o_busy(o_busy), .o_read_array(o_read_array),
    .o_trap_fetch_inhibit(o_trap_fetch_inhibit));
  frsb_prog u_frsb_prog (.i_mode2(i_serial_mode2), .i_txd(o_txd), .o_sclk(sclk), .o_rxd(rxd));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= d;
    i_read <= !wr;
    i_write <= wr;
    do @(posedge i_clock); while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, exp);
  endtask
  task automatic set_abort(input logic [3:0] v);
    i_nmi <= v[0];
    i_wdt_irq <= v[1];
    i_osc_stop_irq <= v[2];
    i_low_volt_irq <= v[3];
  endtask
  task automatic wait_ready;
    logic [31:0] q;
    do bus(1'b0, `FRSB_REG_STATUS, 32'h00000000, q); while (q[0] !== 1'b1);
  endtask
  task automatic do_reset(input logic m2);
    i_resetn <= 1'b0;
    i_serial_mode2 <= m2;
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(`FRSB_REG_STATUS, 32'h00000001);
    rd(`FRSB_REG_ID, 32'h0000003C);
    wr(8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'h00000000);
    rd(`FRSB_REG_CTRL_A, 32'h00000000);
  endtask
  task automatic t_abort;
    logic [31:0] q;
    logic [2:0] c;
    for (int k = 0; k < 4; k++) begin
      c = 3'(k + 1);
      // bench never models low speed or low power mode
      wr(`FRSB_REG_MODE, 32'h00000001);
      wr(`FRSB_REG_CTRL_B, 32'h00000001);
      wr(`FRSB_REG_CTRL_A, {16'h00A5, 5'h00, 3'(k), 1'b0, c, 4'h0});
      repeat (5) @(posedge i_clock);
      chk({31'h0, o_read_array}, 32'h00000000);
      // aborts only in ram-resident mode, vectors taken as in RAM
      set_abort(4'(1 << k));
      @(posedge i_clock);
      set_abort(4'h0);
      repeat (3) @(posedge i_clock);
      chk({31'h0, o_read_array}, 32'h00000001);
      rd(`FRSB_REG_CTRL_A, 32'h00000000);
      rd(`FRSB_REG_STATUS, 32'h00000001);
      bus(1'b0, `FRSB_REG_LOCKS, 32'h00000000, q);
      chk({31'h0, q[16 + k]}, {31'h0, k == 1});
    end
    wr(`FRSB_REG_CTRL_A, {21'h0, 3'h1, 1'b0, `FRSB_CMD_ERASE, 4'h0});
    wait_ready();
    rd(`FRSB_REG_STATUS, 32'h00000001);
    bus(1'b0, `FRSB_REG_LOCKS, 32'h00000000, q);
    chk({31'h0, q[17]}, 32'h00000000);
    wr(`FRSB_REG_CTRL_A, {16'h00A5, 5'h0, 3'h1, 1'b0, `FRSB_CMD_PROGRAM, 4'h0});
    wait_ready();
    rd(`FRSB_REG_STATUS, 32'h00000001);
  endtask
  task automatic t_trap;
    wr(`FRSB_REG_CTRL_A, 32'h00000000);
    repeat (2) @(posedge i_clock);
    chk({31'h0, o_trap_fetch_inhibit}, 32'h00000001);
    wr(`FRSB_REG_CTRL_A, 32'h00000001);
    repeat (2) @(posedge i_clock);
    chk({31'h0, o_trap_fetch_inhibit}, 32'h00000000);
  endtask
  task automatic t_serial1;
    logic [7:0] b;
    u_frsb_prog.send_byte(8'h11);
    u_frsb_prog.send_byte(8'h03);
    repeat (40) @(posedge i_clock);
    chk({31'h0, o_busy, o_txd}, 32'h00000001);
    u_frsb_prog.send_byte(8'h3C);
    u_frsb_prog.send_byte(8'h83);
    u_frsb_prog.send_byte(8'hC3);
    u_frsb_prog.send_byte(8'h03);
    chk({31'h0, o_busy}, 32'h00000001);
    u_frsb_prog.recv_byte(b);
    chk({24'h0, b}, 32'h000000C3);
  endtask
  task automatic t_mode2;
    logic [7:0] b;
    do_reset(1'b1);
    wr(`FRSB_REG_MODE, 32'h00000001);
    wr(`FRSB_REG_CTRL_B, 32'h00000001);
    // block 2 holds no control program
    wr(`FRSB_REG_CTRL_A, {16'h005A, 5'h0, 3'h2, 1'b1, `FRSB_CMD_PROGRAM, 4'h0});
    repeat (5) @(posedge i_clock);
    chk({31'h0, o_busy}, 32'h00000001);
    repeat (OPC + 5) @(posedge i_clock);
    chk({31'h0, o_busy}, 32'h00000000);
    // uart read back of the programmed block
    u_frsb_prog.send_uart(8'h3C);
    u_frsb_prog.xfer_uart(8'h02, b);
    chk({24'h0, b}, 32'h0000005A);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    do_reset(1'b0);
    t_regs();
    t_abort();
    t_trap();
    t_serial1();
    t_mode2();
    wrap_up();
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule // frsb_top_tb
